// [src/ssa_consts.vh]
/*
  Constants for the scalar shift / add datapath: word widths, floating-point
  field layout, special values and unit latencies.
  Assumes it is included by bare name from the design files under src/.
*/
`ifndef SSA_CONSTS_VH
`define SSA_CONSTS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SSA_WORD_W 64
`define SSA_ADDR_W 32
`define SSA_DES_W 3
`define SSA_DES_ZERO 3'h0

// ----------------------------------------------------------------------------
// Floating-point word layout
// ----------------------------------------------------------------------------
`define SSA_FP_SIGN 63
`define SSA_FP_EXP_HI 62
`define SSA_FP_EXP_LO 48
`define SSA_FP_EXP_W 15
`define SSA_FP_COEF_W 48
`define SSA_FP_LZ_W 6

// ----------------------------------------------------------------------------
// Special values and shift limits
// ----------------------------------------------------------------------------
`define SSA_SIGN_ONLY 64'h8000_0000_0000_0000
`define SSA_WORD_ZERO 64'h0000_0000_0000_0000
`define SSA_DEF_COUNT 32'h0000_0001
`define SSA_CIRC_MAX 32'h0000_0040
`define SSA_SHIFT_MAX 32'h0000_007F
`define SSA_FP_ALIGN_MAX 15'h0030

// ----------------------------------------------------------------------------
// Timing: clock period, unit latencies in clock periods, cycle counts
// ----------------------------------------------------------------------------
`define SSA_CLK_NS 8
`define SSA_CP_NS 8
`define SSA_SH_LAT_CP 3
`define SSA_IA_LAT_CP 2
`define SSA_FA_LAT_CP 7
`define SSA_SH_LAT_CYC ((`SSA_SH_LAT_CP * `SSA_CP_NS) / `SSA_CLK_NS)
`define SSA_IA_LAT_CYC ((`SSA_IA_LAT_CP * `SSA_CP_NS) / `SSA_CLK_NS)
`define SSA_FA_LAT_CYC ((`SSA_FA_LAT_CP * `SSA_CP_NS) / `SSA_CLK_NS)

`endif

// [src/ssa_pipe.v]
/*
  Fixed-latency result pipe: a valid bit and a data word move one stage per
  clock, so a new entry may enter on every edge.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module ssa_pipe #(
  parameter W = 67,
  parameter DEPTH = 3
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  // Entry side
  input wire vld_in,
  input wire [W-1:0] data_in,
  // Exit side
  output wire vld_out,
  output wire [W-1:0] data_out
);

  wire [DEPTH:0] vch;
  wire [W*(DEPTH+1)-1:0] dch;

  assign vch[0] = vld_in;
  assign dch[W-1:0] = data_in;

  // ------------------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : stg
      reg v;
      reg [W-1:0] d;
      // One register stage, independent of any other entry in flight
      always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          v <= 1'b0;
          d <= {W{1'b0}};
        end else begin
          v <= vch[g];
          d <= dch[g*W +: W];
        end
      end
      assign vch[g+1] = v;
      assign dch[(g+1)*W +: W] = d;
    end
  endgenerate

  assign vld_out = vch[DEPTH];
  assign data_out = dch[DEPTH*W +: W];

endmodule // ssa_pipe

`default_nettype wire

// [src/ssa_top.v]
/*
  Scalar double-shift unit, integer add/subtract unit and floating-point
  add/subtract unit, each a fully pipelined fixed-latency unit.
  Assumes issue logic holds issue on reserved registers and presents the
  register values together with the designators in the issue cycle.
*/
// Operation
// - Double shift joins destination and first operand into 128 bits.
// - Shift count comes from address register, unsigned, all 32 bits used.
// - Count designator zero gives a shift count of one.
// - Operand designator zero joins destination with a zero word.
// - Equal nonzero designators and count at most 64 rotate circularly.
// - Counts above 64 shift end-off with zero fill.
// - Differing designators leave the operand register unwritten; destination only.
// - Left shift: destination high, operand low, upper half written back.
// - Right shift: operand high, destination low, low 7 count bits, lower half.
// - Counts above 127 write zero to the destination.
// - Double shift issues in one period, result three periods later.
// - Integer add gives 64-bit sum, no overflow; first zero passes second.
// - Integer add with both designators zero writes only bit 63.
// - Integer subtract gives difference; both designators zero write sign bit.
// - Subtract with first designator zero writes negation of second operand.
// - Integer add/subtract issue in one period, result two periods later.
// - Floating adder treats operands as floating and always normalizes.
// - First designator zero gives normalized second operand or its negation.
// - Sign set with zero exponent and coefficient counts as zero.
// - Floating add issues in one period, result seven later; issue holds.
// - Bit 63 sign, bits 62..48 exponent, low 48 bits coefficient.
`timescale 1ns/10ps
`default_nettype none
`include "ssa_consts.vh"

module ssa_top (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  // Double-shift issue
  input wire sh_issue_in,
  input wire sh_right_in,
  input wire [`SSA_DES_W-1:0] sh_dest_des_in,
  input wire [`SSA_DES_W-1:0] sh_opd_des_in,
  input wire [`SSA_DES_W-1:0] sh_cnt_des_in,
  input wire [`SSA_WORD_W-1:0] sh_dest_val_in,
  input wire [`SSA_WORD_W-1:0] sh_opd_val_in,
  input wire [`SSA_ADDR_W-1:0] sh_cnt_val_in,
  // Double-shift result
  output wire sh_ready_out,
  output wire [`SSA_DES_W-1:0] sh_dest_des_out,
  output wire [`SSA_WORD_W-1:0] sh_result_out,
  // Integer add issue
  input wire ia_issue_in,
  input wire ia_sub_in,
  input wire [`SSA_DES_W-1:0] ia_dest_des_in,
  input wire [`SSA_DES_W-1:0] ia_first_des_in,
  input wire [`SSA_DES_W-1:0] ia_second_des_in,
  input wire [`SSA_WORD_W-1:0] ia_first_val_in,
  input wire [`SSA_WORD_W-1:0] ia_second_val_in,
  // Integer add result
  output wire ia_ready_out,
  output wire [`SSA_DES_W-1:0] ia_dest_des_out,
  output wire [`SSA_WORD_W-1:0] ia_result_out,
  // Floating add issue
  input wire fa_issue_in,
  input wire fa_sub_in,
  input wire [`SSA_DES_W-1:0] fa_dest_des_in,
  input wire [`SSA_DES_W-1:0] fa_first_des_in,
  input wire [`SSA_DES_W-1:0] fa_second_des_in,
  input wire [`SSA_WORD_W-1:0] fa_first_val_in,
  input wire [`SSA_WORD_W-1:0] fa_second_val_in,
  // Floating add result
  output wire fa_ready_out,
  output wire [`SSA_DES_W-1:0] fa_dest_des_out,
  output wire [`SSA_WORD_W-1:0] fa_result_out
);

  // Each result pipe carries the destination designator beside the word
  localparam PW = `SSA_DES_W + `SSA_WORD_W;

  // --------------------------------------------------------------------------
  // Double-shift unit
  // --------------------------------------------------------------------------

  // Effective count and second word
  wire [`SSA_ADDR_W-1:0] sh_count;
  wire [`SSA_WORD_W-1:0] sh_opd;
  wire sh_circ;
  wire [`SSA_WORD_W-1:0] sh_low_word;
  wire [127:0] sh_left_cat;
  wire [127:0] sh_right_cat;
  wire [127:0] sh_left;
  wire [127:0] sh_right;
  wire sh_over;
  wire [`SSA_WORD_W-1:0] sh_result;

  // Count or operand designator zero reads no register: count one, operand a zero word
  assign sh_count = (sh_cnt_des_in == `SSA_DES_ZERO) ?
                    `SSA_DEF_COUNT : sh_cnt_val_in;
  assign sh_opd = (sh_opd_des_in == `SSA_DES_ZERO) ?
                  `SSA_WORD_ZERO : sh_opd_val_in;

  // Same register on both halves: its one value fills both, so the shift wraps
  assign sh_circ = (sh_dest_des_in == sh_opd_des_in) &&
                   (sh_opd_des_in != `SSA_DES_ZERO) &&
                   (sh_count <= `SSA_CIRC_MAX);
  assign sh_low_word = sh_circ ? sh_dest_val_in : sh_opd;

  // Join the halves in the order of each direction
  assign sh_left_cat = {sh_dest_val_in, sh_low_word};
  assign sh_right_cat = {sh_low_word, sh_dest_val_in};

  // Only the low seven count bits steer the shifters; counts past 127 are caught below
  // Logical shifts drop bits off the end and fill with zeros
  assign sh_left = sh_left_cat << sh_count[6:0];
  assign sh_right = sh_right_cat >> sh_count[6:0];

  // Full 32-bit compare so high count bits cannot alias a small shift
  assign sh_over = (sh_count > `SSA_SHIFT_MAX);

  // Only the destination word leaves the unit; the operand is never written
  assign sh_result = sh_over ? `SSA_WORD_ZERO :
                     (sh_right_in ? sh_right[63:0] : sh_left[127:64]);

  // The pipe depth is the whole latency; no stage waits on another
  // Three-period result pipe, new entry every edge
  ssa_pipe #(
    .W(PW),
    .DEPTH(`SSA_SH_LAT_CYC)
  ) u_sh_pipe (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .vld_in(sh_issue_in),
    .data_in({sh_dest_des_in, sh_result}),
    .vld_out(sh_ready_out),
    .data_out({sh_dest_des_out, sh_result_out})
  );

  // --------------------------------------------------------------------------
  // Integer add / subtract unit
  // --------------------------------------------------------------------------

  // Zero designators read as zero words
  wire [`SSA_WORD_W-1:0] ia_a;
  wire [`SSA_WORD_W-1:0] ia_b;
  wire ia_both_zero;
  wire [`SSA_WORD_W-1:0] ia_result;

  assign ia_a = (ia_first_des_in == `SSA_DES_ZERO) ? `SSA_WORD_ZERO : ia_first_val_in;
  assign ia_b = (ia_second_des_in == `SSA_DES_ZERO) ? `SSA_WORD_ZERO : ia_second_val_in;
  assign ia_both_zero = (ia_first_des_in == `SSA_DES_ZERO) &&
                        (ia_second_des_in == `SSA_DES_ZERO);

  // No overflow flag: carries out of bit 63 are simply lost
  // Wrapping sum or difference; zero first operand passes or negates the second
  assign ia_result = ia_both_zero ? `SSA_SIGN_ONLY :
                     (ia_sub_in ? (ia_a - ia_b) :
                      (ia_a + ia_b));

  // Two-period result pipe
  ssa_pipe #(
    .W(PW),
    .DEPTH(`SSA_IA_LAT_CYC)
  ) u_ia_pipe (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .vld_in(ia_issue_in),
    .data_in({ia_dest_des_in, ia_result}),
    .vld_out(ia_ready_out),
    .data_out({ia_dest_des_out, ia_result_out})
  );

  // --------------------------------------------------------------------------
  // Floating add / subtract unit
  // --------------------------------------------------------------------------

  // Leading zeros of a coefficient, 48 when it is all zero
  function [`SSA_FP_LZ_W-1:0] lzc48;
    input [`SSA_FP_COEF_W-1:0] c;
    integer n;
    reg found;
    begin
      lzc48 = 6'd48;
      found = 1'b0;
      for (n = `SSA_FP_COEF_W - 1; n >= 0; n = n - 1) begin
        if (!found && c[n]) begin
          lzc48 = 6'd47 - n[5:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // Operand fields
  wire [`SSA_WORD_W-1:0] fa_a;
  wire [`SSA_WORD_W-1:0] fa_b;
  wire fa_sa;
  wire fa_sb;
  wire [`SSA_FP_EXP_W-1:0] fa_ea;
  wire [`SSA_FP_EXP_W-1:0] fa_eb;
  wire [`SSA_FP_COEF_W-1:0] fa_ma;
  wire [`SSA_FP_COEF_W-1:0] fa_mb;

  // A zero designator reads as a zero word; subtract flips the second sign
  assign fa_a = (fa_first_des_in == `SSA_DES_ZERO) ? `SSA_WORD_ZERO :
                fa_first_val_in;
  assign fa_b = (fa_second_des_in == `SSA_DES_ZERO) ? `SSA_WORD_ZERO :
                fa_second_val_in;
  assign fa_sa = fa_a[`SSA_FP_SIGN];
  assign fa_sb = fa_b[`SSA_FP_SIGN] ^ fa_sub_in;
  assign fa_ea = fa_a[`SSA_FP_EXP_HI:`SSA_FP_EXP_LO];
  assign fa_eb = fa_b[`SSA_FP_EXP_HI:`SSA_FP_EXP_LO];
  assign fa_ma = fa_a[`SSA_FP_COEF_W-1:0];
  assign fa_mb = fa_b[`SSA_FP_COEF_W-1:0];

  // Align, add magnitudes, normalize
  // Alignment shifts drop the bits that fall off; there is no guard or round bit
  reg fa_sx;
  reg fa_sy;
  reg [`SSA_FP_EXP_W-1:0] fa_ex;
  reg [`SSA_FP_EXP_W-1:0] fa_diff;
  reg [`SSA_FP_COEF_W-1:0] fa_mx;
  reg [`SSA_FP_COEF_W-1:0] fa_my;
  reg [`SSA_FP_COEF_W:0] fa_sum;
  reg fa_sr;
  reg [`SSA_FP_EXP_W-1:0] fa_er;
  reg [`SSA_FP_COEF_W-1:0] fa_mr;
  reg [`SSA_FP_LZ_W-1:0] fa_lz;
  reg [`SSA_WORD_W-1:0] fa_result;

  always @* begin
    fa_sx = fa_sa;
    fa_sy = fa_sb;
    fa_ex = fa_ea;
    fa_diff = {`SSA_FP_EXP_W{1'b0}};
    fa_mx = fa_ma;
    fa_my = fa_mb;
    fa_sum = {(`SSA_FP_COEF_W+1){1'b0}};
    fa_sr = 1'b0;
    fa_er = {`SSA_FP_EXP_W{1'b0}};
    fa_mr = {`SSA_FP_COEF_W{1'b0}};
    fa_lz = {`SSA_FP_LZ_W{1'b0}};
    fa_result = `SSA_WORD_ZERO;
    // Exponents are compared as unsigned fields; no bias is removed
    // Larger exponent first; the other coefficient is shifted into place
    if (fa_ea >= fa_eb) begin
      fa_diff = fa_ea - fa_eb;
      fa_my = (fa_diff >= `SSA_FP_ALIGN_MAX) ? {`SSA_FP_COEF_W{1'b0}} :
              (fa_mb >> fa_diff[5:0]);
    end else begin
      fa_sx = fa_sb;
      fa_sy = fa_sa;
      fa_ex = fa_eb;
      fa_mx = fa_mb;
      fa_diff = fa_eb - fa_ea;
      fa_my = (fa_diff >= `SSA_FP_ALIGN_MAX) ? {`SSA_FP_COEF_W{1'b0}} :
              (fa_ma >> fa_diff[5:0]);
    end
    // Signed-magnitude add; a zero coefficient contributes nothing
    if (fa_sx == fa_sy) begin
      fa_sum = {1'b0, fa_mx} + {1'b0, fa_my};
      fa_sr = fa_sx;
    end else if (fa_mx >= fa_my) begin
      fa_sum = {1'b0, fa_mx} - {1'b0, fa_my};
      fa_sr = fa_sx;
    end else begin
      fa_sum = {1'b0, fa_my} - {1'b0, fa_mx};
      fa_sr = fa_sy;
    end
    // Exponent overflow or underflow wraps silently; no range flag is raised
    // Carry out moves the point right; otherwise shift out leading zeros
    if (fa_sum[`SSA_FP_COEF_W]) begin
      fa_mr = fa_sum[`SSA_FP_COEF_W:1];
      fa_er = fa_ex + 15'h0001;
    end else begin
      fa_lz = lzc48(fa_sum[`SSA_FP_COEF_W-1:0]);
      fa_mr = fa_sum[`SSA_FP_COEF_W-1:0] << fa_lz;
      fa_er = fa_ex - {9'h000, fa_lz};
    end
    // A cancelled sum must not leave a stray sign with zero fields
    // A zero magnitude, signed or not, leaves as a zero word
    if (fa_mr == {`SSA_FP_COEF_W{1'b0}}) begin
      fa_result = `SSA_WORD_ZERO;
    end else begin
      fa_result = {fa_sr, fa_er, fa_mr};
    end
  end

  // Seven-period result pipe
  ssa_pipe #(
    .W(PW),
    .DEPTH(`SSA_FA_LAT_CYC)
  ) u_fa_pipe (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .vld_in(fa_issue_in),
    .data_in({fa_dest_des_in, fa_result}),
    .vld_out(fa_ready_out),
    .data_out({fa_dest_des_out, fa_result_out})
  );

endmodule // ssa_top

`default_nettype wire

// [verification/scalar_shift_add_units_tb.sv]
/*
  Self-checking bench for ssa_top with the issue-side partner model.
  Assumes ssa_top, ssa_issue_model and ssa_monitor are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module scalar_shift_add_units_tb;
  localparam logic [63:0] va = 64'h0123_4567_89AB_CDEF, vb = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] one = 64'h4001_8000_0000_0000, two = 64'h4002_8000_0000_0000;
  localparam logic [63:0] un = 64'h4010_0000_8000_0000;
  logic clk_in = 1'b0, rst_b_in = 1'b0, sh_issue_in = 1'b0, sh_right_in = 1'b0;
  logic ia_issue_in = 1'b0, ia_sub_in = 1'b0, fa_issue_in = 1'b0, fa_sub_in = 1'b0;
  logic [2:0] sh_dest_des_in = '0, sh_opd_des_in = '0, sh_cnt_des_in = '0;
  logic [2:0] ia_dest_des_in = '0, ia_first_des_in = '0, ia_second_des_in = '0;
  logic [2:0] fa_dest_des_in = '0, fa_first_des_in = '0, fa_second_des_in = '0;
  logic [63:0] sh_dest_val_in = '0, sh_opd_val_in = '0, ia_first_val_in = '0;
  logic [63:0] ia_second_val_in = '0, fa_first_val_in = '0, fa_second_val_in = '0;
  logic [31:0] sh_cnt_val_in = '0;
  wire sh_ready_out, ia_ready_out, fa_ready_out;
  wire [2:0] sh_dest_des_out, ia_dest_des_out, fa_dest_des_out;
  wire [63:0] sh_result_out, ia_result_out, fa_result_out;
  wire [7:0] rsv_out;
  // Registers awaiting a result: reserved ones plus the issue now presented
  wire [7:0] busy = rsv_out |
    (sh_issue_in ? 8'h01 << sh_dest_des_in : 8'h00) |
    (ia_issue_in ? 8'h01 << ia_dest_des_in : 8'h00) |
    (fa_issue_in ? 8'h01 << fa_dest_des_in : 8'h00);
  logic [66:0] sh_q[$], ia_q[$], fa_q[$];
  int n_mismatch = 0, samples_checked = 0;

  always #4 clk_in = ~clk_in;
  ssa_top ssa_top_inst (.*);
  ssa_issue_model ssa_issue_model_inst (.*);

  task check(input logic [66:0] seen, input logic [66:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hold issue while a register that the operation needs awaits a result
  task hold(input logic [7:0] need);
    int w;
    @(negedge clk_in);
    for (w = 0; w < 20 && (busy & need) != 8'h00; w++) begin
      @(posedge clk_in);
      sh_issue_in <= 1'b0;
      ia_issue_in <= 1'b0;
      fa_issue_in <= 1'b0;
      @(negedge clk_in);
    end
    if (w == 20) begin
      n_mismatch++;
      end_sim;
    end
    @(posedge clk_in);
  endtask

  // Results are compared in order of issue, mid-cycle
  always @(negedge clk_in) begin
    if (sh_ready_out === 1'b1)
      check({sh_dest_des_out, sh_result_out}, sh_q.size() ? sh_q.pop_front() : 67'hx);
    if (ia_ready_out === 1'b1)
      check({ia_dest_des_out, ia_result_out}, ia_q.size() ? ia_q.pop_front() : 67'hx);
    if (fa_ready_out === 1'b1)
      check({fa_dest_des_out, fa_result_out}, fa_q.size() ? fa_q.pop_front() : 67'hx);
  end

  function automatic logic [63:0] sh_ref(input logic rt, input logic [2:0] dd, od, cd,
      input logic [63:0] dv, ov, input logic [31:0] cv);
    logic [31:0] n;
    logic [63:0] lo;
    logic [127:0] w;
    n = (cd == 3'h0) ? 32'h0000_0001 : cv;
    lo = (od == 3'h0) ? '0 : ov;
    if (dd == od && dd != 3'h0 && n <= 32'h0000_0040) lo = dv;
    w = rt ? ({lo, dv} >> n[6:0]) : ({dv, lo} << n[6:0]);
    return (n > 32'h0000_007F) ? '0 : (rt ? w[63:0] : w[127:64]);
  endfunction

  task go_sh(input logic rt, input logic [2:0] dd, od, cd, input logic [63:0] dv, ov,
      input logic [31:0] cv);
    hold((8'h01 << dd) | ((od != 3'h0) ? 8'h01 << od : 8'h00));
    sh_issue_in <= 1'b1;
    sh_right_in <= rt;
    sh_dest_des_in <= dd;
    sh_opd_des_in <= od;
    sh_cnt_des_in <= cd;
    sh_dest_val_in <= dv;
    sh_opd_val_in <= ov;
    sh_cnt_val_in <= cv;
    sh_q.push_back({dd, sh_ref(rt, dd, od, cd, dv, ov, cv)});
  endtask

  task go_ia(input logic sub, input logic [2:0] d, j, k, input logic [63:0] a, b);
    logic [63:0] x, y;
    x = (j == 3'h0) ? '0 : a;
    y = (k == 3'h0) ? '0 : b;
    hold((8'h01 << d) | ((j != 3'h0) ? 8'h01 << j : 8'h00) |
      ((k != 3'h0) ? 8'h01 << k : 8'h00));
    ia_issue_in <= 1'b1;
    ia_sub_in <= sub;
    ia_dest_des_in <= d;
    ia_first_des_in <= j;
    ia_second_des_in <= k;
    ia_first_val_in <= a;
    ia_second_val_in <= b;
    if (j == 3'h0 && k == 3'h0) ia_q.push_back({d, 64'h8000_0000_0000_0000});
    else ia_q.push_back({d, sub ? x - y : x + y});
  endtask

  task go_fa(input logic sub, input logic [2:0] d, j, k, input logic [63:0] a, b, e);
    hold((8'h01 << d) | ((j != 3'h0) ? 8'h01 << j : 8'h00) |
      ((k != 3'h0) ? 8'h01 << k : 8'h00));
    fa_issue_in <= 1'b1;
    fa_sub_in <= sub;
    fa_dest_des_in <= d;
    fa_first_des_in <= j;
    fa_second_des_in <= k;
    fa_first_val_in <= a;
    fa_second_val_in <= b;
    fa_q.push_back({d, e});
  endtask

  // Stop issuing, wait for all results, then see every reservation released
  task drain;
    int i;
    @(posedge clk_in);
    sh_issue_in <= 1'b0;
    ia_issue_in <= 1'b0;
    fa_issue_in <= 1'b0;
    for (i = 0; i < 30 && sh_q.size() + ia_q.size() + fa_q.size() != 0; i++) @(negedge clk_in);
    if (i == 30) begin
      n_mismatch++;
      end_sim;
    end
    @(negedge clk_in);
    check(67'(rsv_out), '0);
  endtask

  // Double shifts, both directions, each issued as soon as its registers are free
  task t_shift;
    for (int r = 0; r < 2; r++) begin
      go_sh(r[0], 3'h1, 3'h2, 3'h3, va, vb, 32'h0000_0004);
      go_sh(r[0], 3'h2, 3'h4, 3'h0, va, vb, 32'hFFFF_FFFF);
      go_sh(r[0], 3'h4, 3'h0, 3'h5, va, vb, 32'h0000_0011);
      go_sh(r[0], 3'h3, 3'h3, 3'h1, va, vb, 32'h0000_0005);
      go_sh(r[0], 3'h3, 3'h3, 3'h1, 64'h8123_4567_89AB_CDEF, 64'h8123_4567_89AB_CDEF,
        32'h0000_0041);
      go_sh(r[0], 3'h5, 3'h6, 3'h2, va, vb, 32'h0000_007F);
      go_sh(r[0], 3'h6, 3'h1, 3'h2, va, vb, 32'h0000_0080);
      go_sh(r[0], 3'h7, 3'h1, 3'h2, va, vb, 32'h0001_0005);
    end
    drain;
  endtask

  // Integer add with every designator case, subtract with all but a zero second designator
  task t_int;
    go_ia(1'b0, 3'h1, 3'h2, 3'h3, 64'hFFFF_FFFF_FFFF_FFFF, vb);
    go_ia(1'b0, 3'h2, 3'h0, 3'h3, va, vb);
    go_ia(1'b0, 3'h3, 3'h0, 3'h0, va, vb);
    go_ia(1'b1, 3'h4, 3'h1, 3'h2, va, vb);
    go_ia(1'b1, 3'h5, 3'h0, 3'h0, va, vb);
    go_ia(1'b1, 3'h6, 3'h0, 3'h7, va, vb);
    go_ia(1'b0, 3'h7, 3'h1, 3'h0, va, vb);
    drain;
  endtask

  // Floating add and subtract, normalizing and signed zero
  task t_float;
    go_fa(1'b0, 3'h1, 3'h2, 3'h3, one, one, two);
    go_fa(1'b1, 3'h2, 3'h2, 3'h3, two, one, one);
    go_fa(1'b0, 3'h3, 3'h0, 3'h3, one, un, 64'h4000_8000_0000_0000);
    go_fa(1'b1, 3'h4, 3'h0, 3'h3, one, un, 64'hC000_8000_0000_0000);
    go_fa(1'b0, 3'h5, 3'h2, 3'h3, 64'h8000_0000_0000_0000, one, one);
    go_fa(1'b1, 3'h6, 3'h2, 3'h3, one, one, '0);
    drain;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(negedge clk_in);
    check(67'({sh_ready_out, ia_ready_out, fa_ready_out}), '0);
    t_shift;
    t_int;
    t_float;
    end_sim;
  end
endmodule // scalar_shift_add_units_tb

bind ssa_top ssa_monitor ssa_monitor_inst (.*);
`default_nettype wire

// [verification/ssa_issue_model.sv]
/*
  Issue-side partner: keeps a reservation bit per scalar register.
  Assumes it watches the issue and result ports of ssa_top; one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ssa_issue_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Issues
  input wire logic sh_issue_in,
  input wire logic [2:0] sh_dest_des_in,
  input wire logic ia_issue_in,
  input wire logic [2:0] ia_dest_des_in,
  input wire logic fa_issue_in,
  input wire logic [2:0] fa_dest_des_in,
  // Results
  input wire logic sh_ready_out,
  input wire logic [2:0] sh_dest_des_out,
  input wire logic ia_ready_out,
  input wire logic [2:0] ia_dest_des_out,
  input wire logic fa_ready_out,
  input wire logic [2:0] fa_dest_des_out,
  // Reservations
  output var logic [7:0] rsv_out
);
  logic [7:0] next_rsv;
  // Release on result, reserve on issue; a new issue wins
  always_comb begin
    next_rsv = rsv_out;
    if (sh_ready_out) next_rsv[sh_dest_des_out] = 1'b0;
    if (ia_ready_out) next_rsv[ia_dest_des_out] = 1'b0;
    if (fa_ready_out) next_rsv[fa_dest_des_out] = 1'b0;
    if (sh_issue_in) next_rsv[sh_dest_des_in] = 1'b1;
    if (ia_issue_in) next_rsv[ia_dest_des_in] = 1'b1;
    if (fa_issue_in) next_rsv[fa_dest_des_in] = 1'b1;
  end
  // Reservation register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rsv_out <= '0;
    else rsv_out <= next_rsv;
  end
endmodule // ssa_issue_model
`default_nettype wire

// [verification/ssa_monitor.sv]
/*
  Checker for ssa_top: unit latencies, shift result tag, large shift counts and integer special cases.
  Assumes it is bound to ssa_top; one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ssa_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Shift unit
  input wire logic sh_issue_in,
  input wire logic [2:0] sh_dest_des_in,
  input wire logic [2:0] sh_cnt_des_in,
  input wire logic [31:0] sh_cnt_val_in,
  input wire logic sh_ready_out,
  input wire logic [2:0] sh_dest_des_out,
  input wire logic [63:0] sh_result_out,
  // Integer unit
  input wire logic ia_issue_in,
  input wire logic ia_sub_in,
  input wire logic [2:0] ia_first_des_in,
  input wire logic [2:0] ia_second_des_in,
  input wire logic [63:0] ia_second_val_in,
  input wire logic ia_ready_out,
  input wire logic [63:0] ia_result_out,
  // Float unit
  input wire logic fa_issue_in,
  input wire logic fa_ready_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Result-ready steps of each unit
  sequence sh_done; ##3 sh_ready_out; endsequence
  sequence ia_done; ##2 ia_ready_out; endsequence
  sequence fa_done; ##7 fa_ready_out; endsequence
  chk_sh_latency: assert property (sh_issue_in |-> sh_done)
    else $error("shift result not ready three cycles after issue");
  chk_sh_no_spur: assert property (sh_ready_out |-> $past(sh_issue_in, 3))
    else $error("shift ready without an issue");
  chk_sh_dest_tag: assert property (sh_issue_in |-> ##3 sh_dest_des_out == $past(sh_dest_des_in, 3))
    else $error("shift result for wrong destination");
  chk_sh_far_zero: assert property ((sh_issue_in && sh_cnt_des_in != 3'h0 &&
    sh_cnt_val_in > 32'h0000_007F) |-> ##3 sh_result_out == '0)
    else $error("large shift count did not clear");
  chk_ia_latency: assert property (ia_issue_in |-> ia_done)
    else $error("integer result not ready two cycles after issue");
  chk_ia_sign_only: assert property ((ia_issue_in && ia_first_des_in == 3'h0 &&
    ia_second_des_in == 3'h0) |-> ##2 ia_result_out == 64'h8000_0000_0000_0000)
    else $error("both designators zero gave wrong word");
  chk_ia_pass_neg: assert property ((ia_issue_in && ia_first_des_in == 3'h0 &&
    ia_second_des_in != 3'h0) |-> ##2 ia_result_out == ($past(ia_sub_in, 2) ?
    -$past(ia_second_val_in, 2) : $past(ia_second_val_in, 2)))
    else $error("first designator zero gave wrong word");
  chk_fa_latency: assert property (fa_issue_in |-> fa_done)
    else $error("float result not ready seven cycles after issue");
  chk_fa_no_spur: assert property (fa_ready_out |-> $past(fa_issue_in, 7))
    else $error("float ready without an issue");
endmodule // ssa_monitor
`default_nettype wire
